// file: rtl/cbr_pkg.sv
/*
  constants for the clock b rate and preset block: register offsets,
  status bit positions, rate codes and tick divider counts.
  assumes a 100 MHz system clock.
*/
package cbr_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 16;
  localparam logic [3:0]  OFS_B_STATUS  = 4'h0;
  localparam logic [3:0]  OFS_B_COUNT   = 4'h2;
  localparam logic [3:0]  OFS_A_PRESET  = 4'h4;
  localparam logic [3:0]  OFS_B_PRESET  = 4'h6;
  localparam logic [3:0]  OFS_IRQ_STAT  = 4'h8;
  localparam logic [3:0]  OFS_IRQ_MASK  = 4'ha;
  localparam int          BIT_ENABLE    = 0;
  localparam int          BIT_RATE_LO   = 1;
  localparam int          BIT_FEED      = 5;
  localparam int          BIT_OVF_IE    = 6;
  localparam int          BIT_OVF_FLAG  = 7;
  localparam int          BIT_MAINT_INT = 9;
  // flag bit 7 writable so software can clear it; bit 9 is a pulse, never stored
  localparam logic [15:0] STATUS_WMASK  = 16'h00ff;
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [7:0]  B_PRESET_RST  = 8'h00;
  localparam logic [15:0] A_PRESET_RST  = 16'h0000;
  localparam int          IRQ_OVF       = 0;
  localparam int          IRQ_MAINT     = 1;
  localparam int          SYS_CLK_HZ    = 100_000_000;
  localparam int          DIV_1MHZ      = SYS_CLK_HZ / 1_000_000;
  localparam int          DIV_DECADE    = 10;
  typedef enum logic [2:0] {
    CBR_RATE_NONE  = 3'h0,
    CBR_RATE_1M    = 3'h1,
    CBR_RATE_100K  = 3'h2,
    CBR_RATE_10K   = 3'h3,
    CBR_RATE_1K    = 3'h4,
    CBR_RATE_100   = 3'h5,
    CBR_RATE_TRIG3 = 3'h6,
    CBR_RATE_LINE  = 3'h7
  } cbr_rate_t;
endpackage

// file: rtl/cbr_tick_gen.sv
/*
  crystal rate tick generator: one-cycle pulses at 1 MHz down to 100 Hz.
  assumes the 100 MHz system clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module cbr_tick_gen
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  output logic [4:0]      tick_ff
);
  import cbr_pkg::*;

  logic [6:0]  pre_ff,  nxt_pre;
  logic [15:0] dec_ff,  nxt_dec;
  logic [4:0]  nxt_tick;
  logic        base;

  // decades kept as one packed set of four 4-bit counters
  always_comb
  begin
    nxt_pre  = pre_ff + 7'h01;
    base     = (pre_ff == 7'(DIV_1MHZ - 1));
    nxt_dec  = dec_ff;
    nxt_tick = 5'h00;
    if (base)
    begin
      nxt_pre     = 7'h00;
      nxt_tick[0] = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
        if (i == 0 || nxt_tick[i])
        begin
          if (dec_ff[i*4 +: 4] == 4'(DIV_DECADE - 1))
          begin
            nxt_dec[i*4 +: 4] = 4'h0;
            nxt_tick[i+1]     = 1'b1;
          end
          else
            nxt_dec[i*4 +: 4] = dec_ff[i*4 +: 4] + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pre_ff  <= 7'h00;
      dec_ff  <= 16'h0000;
      tick_ff <= 5'h00;
    end
    else
    begin
      pre_ff  <= nxt_pre;
      dec_ff  <= nxt_dec;
      tick_ff <= nxt_tick;
    end
  end
endmodule

// file: rtl/cbr_clock_b.sv
/*
  clock b: rate select, enable, 8-bit up counter with preset reload,
  overflow flag and interrupt, plus the clock a preset/buffer word.
  assumes synchronous single-cycle trigger and line pulses on clk_sys.
*/
// Behaviour
// - the 3-bit rate field picks none, 1 MHz..100 Hz, the third trigger input or line frequency.
// - status bit 0 lets counter b advance on the selected tick, otherwise it holds.
// - the clock a preset/buffer register is a full 16-bit word.
// - the clock a preset/buffer word is readable and writable while clock a runs.
// - the clock b preset register is 8 bits in the low byte of its word.
// - status bit 7 sets on every counter b overflow.
// - with status bit 6 set each overflow requests an interrupt.
// - with feed bit 5 set and clock a rate zero, b overflows clock counter a.
// - writing maintenance bit 9 raises a clock b interrupt for test.
`timescale 1ns/100ps
module cbr_clock_b
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic [cbr_pkg::ADDR_W-1:0] addr,
  input  wire logic [cbr_pkg::DATA_W-1:0] wdata,
  input  wire logic                    wr_stb,
  input  wire logic                    rd_stb,
  output logic [cbr_pkg::DATA_W-1:0]   rdata_ff,
  input  wire logic                    external_trigger_three,
  input  wire logic                    line_tick,
  input  wire logic                    clock_a_rate_zero,
  output logic                         feed_a_tick_ff,
  output logic                         b_overflow_ff,
  output logic                         irq_ff
);
  import cbr_pkg::*;

  logic [15:0] status_ff, nxt_status;
  logic [7:0]  count_ff,  nxt_count;
  logic [7:0]  bpre_ff,   nxt_bpre;
  logic [15:0] apre_ff,   nxt_apre;
  logic [1:0]  istat_ff,  nxt_istat;
  logic [1:0]  imask_ff,  nxt_imask;
  logic [15:0] nxt_rdata;
  logic        nxt_ovf, nxt_feed, nxt_irq, sel_tick;
  logic [4:0]  xtal_tick;
  cbr_rate_t   rate;

  cbr_tick_gen u_tick
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick_ff (xtal_tick)
  );

  function automatic logic pick_tick(input cbr_rate_t r, input logic [4:0] x,
                                     input logic t3, input logic ln);
    case (r)
      CBR_RATE_NONE:  pick_tick = 1'b0;
      CBR_RATE_1M:    pick_tick = x[0];
      CBR_RATE_100K:  pick_tick = x[1];
      CBR_RATE_10K:   pick_tick = x[2];
      CBR_RATE_1K:    pick_tick = x[3];
      CBR_RATE_100:   pick_tick = x[4];
      CBR_RATE_TRIG3: pick_tick = t3;
      CBR_RATE_LINE:  pick_tick = ln;
      default:        pick_tick = 1'b0;
    endcase
  endfunction

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o, input logic s);
    hit = s && (a == o);
  endfunction

  // tick selection and counter b
  always_comb
  begin
    rate      = cbr_rate_t'(status_ff[BIT_RATE_LO +: 3]);
    sel_tick  = pick_tick(rate, xtal_tick, external_trigger_three, line_tick);
    nxt_count = count_ff;
    nxt_ovf   = 1'b0;
    if (status_ff[BIT_ENABLE] && sel_tick)
    begin
      if (count_ff == 8'hff)
      begin
        nxt_count = bpre_ff;
        nxt_ovf   = 1'b1;
      end
      else
      begin
        nxt_count = count_ff + 8'h01;
      end
    end
    nxt_feed = nxt_ovf && status_ff[BIT_FEED] && clock_a_rate_zero;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count_ff       <= 8'h00;
      b_overflow_ff  <= 1'b0;
      feed_a_tick_ff <= 1'b0;
    end
    else
    begin
      count_ff       <= nxt_count;
      b_overflow_ff  <= nxt_ovf;
      feed_a_tick_ff <= nxt_feed;
    end
  end

  // software registers
  always_comb
  begin
    nxt_status = status_ff;
    nxt_bpre   = bpre_ff;
    nxt_apre   = apre_ff;
    if (hit(addr, OFS_B_STATUS, wr_stb))
    begin
      nxt_status = (wdata & STATUS_WMASK) | (status_ff & ~STATUS_WMASK);
    end
    if (hit(addr, OFS_A_PRESET, wr_stb))
    begin
      nxt_apre = wdata;
    end
    // no guard against running writes; software keeps b stopped
    if (hit(addr, OFS_B_PRESET, wr_stb))
    begin
      nxt_bpre = wdata[7:0];
    end
    // set wins over a same-cycle clear
    if (nxt_ovf)
    begin
      nxt_status[BIT_OVF_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      status_ff <= STATUS_RESET;
      bpre_ff   <= B_PRESET_RST;
      apre_ff   <= A_PRESET_RST;
    end
    else
    begin
      status_ff <= nxt_status;
      bpre_ff   <= nxt_bpre;
      apre_ff   <= nxt_apre;
    end
  end

  // sticky interrupt bits, mask and level request
  always_comb
  begin
    nxt_istat = istat_ff;
    nxt_imask = imask_ff;
    if (hit(addr, OFS_IRQ_MASK, wr_stb))
    begin
      nxt_imask = wdata[1:0];
    end
    if (hit(addr, OFS_IRQ_STAT, wr_stb))
    begin
      nxt_istat = istat_ff & ~wdata[1:0];
    end
    // events land after the clear so a same-cycle set wins
    if (nxt_ovf && status_ff[BIT_OVF_IE])
    begin
      nxt_istat[IRQ_OVF] = 1'b1;
    end
    if (hit(addr, OFS_B_STATUS, wr_stb) && wdata[BIT_MAINT_INT])
    begin
      nxt_istat[IRQ_MAINT] = 1'b1;
    end
    nxt_irq = |(nxt_istat & nxt_imask);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      istat_ff <= 2'h0;
      imask_ff <= 2'h0;
      irq_ff   <= 1'b0;
    end
    else
    begin
      istat_ff <= nxt_istat;
      imask_ff <= nxt_imask;
      irq_ff   <= nxt_irq;
    end
  end

  // read data stand one cycle only, zero otherwise
  always_comb
  begin
    nxt_rdata = 16'h0000;
    if (rd_stb)
    begin
      case (addr)
        OFS_B_STATUS: nxt_rdata = status_ff;
        OFS_B_COUNT:  nxt_rdata = {8'h00, count_ff};
        OFS_A_PRESET: nxt_rdata = apre_ff;
        OFS_B_PRESET: nxt_rdata = {8'h00, bpre_ff};
        OFS_IRQ_STAT: nxt_rdata = {14'h0, istat_ff};
        OFS_IRQ_MASK: nxt_rdata = {14'h0, imask_ff};
        default:      nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rdata_ff <= 16'h0000;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end
endmodule

// file: bench/cbr_monitor.sv
/* port assertions for the clock b block.
   bound onto cbr_clock_b; shadows status and mask writes. */
`timescale 1ns/100ps
module cbr_monitor
  import cbr_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata_ff,
  input wire logic        feed_a_tick_ff,
  input wire logic        b_overflow_ff,
  input wire logic        irq_ff
);
  logic [15:0] st_ff;
  logic [15:0] mk_ff;
  always_ff @(posedge clk_sys)
  begin
    st_ff <= rst ? '0 : (wr_stb && addr == OFS_B_STATUS) ? wdata : st_ff;
    mk_ff <= rst ? '0 : (wr_stb && addr == OFS_IRQ_MASK) ? wdata : mk_ff;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_rd_idle; !rd_stb |=> rdata_ff == 16'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_bp_hi; rd_stb && addr == OFS_B_PRESET |=> rdata_ff[15:8] == 8'h0; endproperty
  a_bp_hi: assert property (p_bp_hi) else $error("b preset high byte set");
  property p_st_hi; rd_stb && addr == OFS_B_STATUS |=> rdata_ff[15:8] == 8'h0; endproperty
  a_st_hi: assert property (p_st_hi) else $error("status high byte set");
  property p_unmap; rd_stb && addr > OFS_IRQ_MASK |=> rdata_ff == 16'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; !st_ff[BIT_ENABLE] [*3] |-> !b_overflow_ff; endproperty
  a_hold: assert property (p_hold) else $error("overflow while stopped");
  property p_irq; b_overflow_ff && st_ff[BIT_OVF_IE] && mk_ff[IRQ_OVF] |-> irq_ff; endproperty
  a_irq: assert property (p_irq) else $error("overflow irq missing");
  property p_feed; feed_a_tick_ff |-> b_overflow_ff && st_ff[BIT_FEED]; endproperty
  a_feed: assert property (p_feed) else $error("feed without overflow");
  property p_maint; wr_stb && addr == OFS_B_STATUS && wdata[9] && mk_ff[1] |-> ##[1:2] irq_ff; endproperty
  a_maint: assert property (p_maint) else $error("test irq missing");
endmodule
bind cbr_clock_b cbr_monitor u_mon (.clk_sys, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata_ff,
  .feed_a_tick_ff, .b_overflow_ff, .irq_ff);

// file: bench/cbr_host.sv
/* host software model on the register port.
   assumes calls start just after a rising clk_sys edge. */
`timescale 1ns/100ps
module cbr_host
  import cbr_pkg::*;
(
  input  wire logic [0:0]              clk_sys,
  input  wire logic [cbr_pkg::DATA_W-1:0] rdata_ff,
  output logic [cbr_pkg::ADDR_W-1:0]   addr,
  output logic [cbr_pkg::DATA_W-1:0]   wdata,
  output logic                         wr_stb,
  output logic                         rd_stb
);
  initial {addr, wdata, wr_stb, rd_stb} = '0;
  // callers touch the b preset only with clock b stopped
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    {addr, wdata, wr_stb} <= {a, v, 1'b1};
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    // idle edge: a following call never re-drives the strobe in this step
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    {addr, rd_stb} <= {a, 1'b1};
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(posedge clk_sys);
    v = rdata_ff;
  endtask
endmodule

// file: bench/tb.sv
/* self-checking bench for the clock b block.
   assumes 100 MHz; trigger pulses every 8th cycle, line every 12th. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
  import cbr_pkg::*;
  logic        clk_sys = 1'b0, rst = 1'b1, external_trigger_three = 1'b0, line_tick = 1'b0, clock_a_rate_zero = 1'b0;
  logic        wr_stb, rd_stb, feed_a_tick_ff, b_overflow_ff, irq_ff;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata_ff, d, a;
  int          failures = 0, checks = 0, n_ovf = 0, n_feed = 0, cyc = 0;
  int          rate_list[7] = '{7, 1, 2, 3, 0, 4, 5};
  cbr_clock_b DUT (.clk_sys, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata_ff, .external_trigger_three, .line_tick,
    .clock_a_rate_zero, .feed_a_tick_ff, .b_overflow_ff, .irq_ff);
  cbr_host host (.clk_sys, .rdata_ff, .addr, .wdata, .wr_stb, .rd_stb);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    external_trigger_three <= (cyc % 8 == 0);
    line_tick <= (cyc % 12 == 0);
    n_ovf <= n_ovf + b_overflow_ff;
    n_feed <= n_feed + feed_a_tick_ff;
  end
  // slow rates never tick within this run, so they expect none
  function automatic int gap(int r, int p);
    int per[8] = '{0, 100, 1000, 10000, 0, 0, 8, 12};
    return per[r] * (256 - p);
  endfunction
  task automatic meas(int r, int p);
    int n, o, f;
    logic [15:0] s;
    logic [15:0] c;
    s = 16'h0061 | 16'(r << 1);
    clock_a_rate_zero <= 1'($urandom);
    host.wr(OFS_IRQ_STAT, 16'h0003);
    o = n_ovf;
    f = n_feed;
    host.wr(OFS_B_STATUS, s);
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(posedge clk_sys);
        n++;
      end while (!b_overflow_ff && n < 2 * gap(r, p) + 2400);
    end
    `CHK("gap", gap(r, p), (b_overflow_ff ? n : 0))
    host.rd(OFS_B_STATUS, d);
    `CHK("status", s | (gap(r, p) ? 16'h0080 : 16'h0), d)
    `CHK("irq", 1'(gap(r, p) != 0), irq_ff)
    host.wr(OFS_B_STATUS, s & 16'hfffe);
    repeat (3) @(posedge clk_sys);
    n = n_ovf;
    host.rd(OFS_B_COUNT, c);
    `CHK("count", 1'b1, 1'(gap(r, p) == 0 || (c >= 16'(p) && c <= 16'h00ff)))
    repeat (30) @(posedge clk_sys);
    host.rd(OFS_B_COUNT, d);
    `CHK("count held", c, d)
    `CHK("held", n, n_ovf)
    `CHK("feed", clock_a_rate_zero ? n - o : 0, n_feed - f)
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #1_000_000;
    failures++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(64));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    host.rd(OFS_B_STATUS, d);
    `CHK("status rst", 16'h0, d)
    a = 16'($urandom);
    host.wr(OFS_A_PRESET, a);
    host.wr(OFS_B_PRESET, a);
    host.rd(OFS_A_PRESET, d);
    `CHK("a preset", a, d)
    host.rd(OFS_B_PRESET, d);
    `CHK("b preset", a & 16'h00ff, d)
    host.rd(4'hc, d);
    `CHK("unmapped", 16'h0, d)
    host.wr(OFS_IRQ_MASK, 16'h0003);
    a = 16'($urandom_range(254, 192));
    host.wr(OFS_B_PRESET, a);
    meas(6, a);
    host.wr(OFS_B_PRESET, 16'h00ff);
    foreach (rate_list[i]) meas(rate_list[i], 255);
    host.wr(OFS_IRQ_STAT, 16'h0003);
    host.wr(OFS_IRQ_MASK, 16'h0002);
    host.wr(OFS_B_STATUS, 16'h0200);
    host.rd(OFS_IRQ_STAT, d);
    `CHK("test stat", 16'h0002, d)
    `CHK("test irq", 1'b1, irq_ff)
    host.wr(OFS_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge clk_sys);
    `CHK("masked irq", 1'b0, irq_ff)
    tally_and_finish();
  end
endmodule
